// >>> logic/pst_pkg.sv
// constants for the partial, scroll and tear-line command handler
package pst_pkg;
	localparam logic [7:0] PST_CMD_PARTIAL_AREA = 8'h30;
	localparam logic [7:0] PST_CMD_SCROLL_AREA = 8'h33;
	localparam logic [7:0] PST_CMD_TEAR_OFF = 8'h34;
	localparam logic [7:0] PST_CMD_TEAR_ON = 8'h35;
	localparam logic [7:0] PST_CMD_PARTIAL_ON = 8'h12;
	localparam logic [7:0] PST_CMD_NORMAL_ON = 8'h13;
	localparam logic [7:0] PST_CMD_SCROLL_START = 8'h37;
	localparam logic [7:0] PST_CMD_SW_RESET = 8'h01;
	localparam logic [2:0] PST_PARTIAL_PARAMS = 3'h4;
	localparam logic [2:0] PST_SCROLL_PARAMS = 3'h6;
	localparam logic [15:0] PST_PARTIAL_START_RST = 16'h0000;
	localparam logic [15:0] PST_SCROLL_RST = 16'h0000;
	localparam logic [1:0] PST_GM_208 = 2'h0;
	localparam logic [1:0] PST_GM_220 = 2'h1;
	localparam logic [15:0] PST_LAST_ROW_208 = 16'h00cf;
	localparam logic [15:0] PST_LAST_ROW_220 = 16'h00db;
	localparam logic [15:0] PST_LAST_ROW_240 = 16'h00ef;
	typedef enum logic [1:0] {
		PST_IDLE = 2'b00,
		PST_PARTIAL = 2'b01,
		PST_SCROLL = 2'b10
	} pst_state_e;
endpackage : pst_pkg

// >>> logic/pst_cmd.sv
// command handler for partial window, scroll partition and tear line off
// Operation
// - 30h command, then four bytes: start high, start low, end high, low
// - partial start and end are memory row addresses
// - equal start and end give a one-row window
// - 33h command, six bytes high first: top, scroll height, bottom
// - scan order 0: top fixed from top, bottom fixed from bottom
// - scan order 1: top fixed from bottom, bottom fixed from top
// - scroll height counts memory lines from scroll start address
// - all three scroll values act as line counts, not row addresses
// - 34h takes no parameter, turns tear line off, drives it low
// - tear-off while already off changes nothing
// - commands accepted in every display and sleep mode
// - partial-on or normal-on leaves vertical scroll mode
// - scan order bit is the refresh direction bit of access control
module pst_cmd
	import pst_pkg::*;
#(
	parameter int ROW_W = 16
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic wr_strobe_in,
	input wire logic cmd_data_select_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [1:0] gate_count_select_in,
	input wire logic scan_order_bit_in,
	input wire logic [ROW_W-1:0] scan_row_in,
	output logic [ROW_W-1:0] partial_start_row_out,
	output logic [ROW_W-1:0] partial_end_row_out,
	output logic [ROW_W-1:0] top_fixed_lines_out,
	output logic [ROW_W-1:0] scroll_height_lines_out,
	output logic [ROW_W-1:0] bottom_fixed_lines_out,
	output logic scroll_mode_out,
	output logic scan_order_bit_out,
	output logic row_in_partial_out,
	output logic row_in_top_fixed_out,
	output logic row_in_bottom_fixed_out,
	output logic tear_signal_enable_out,
	output logic tear_signal_out
);
	logic rst_sync1;
	logic rst_n;
	pst_state_e state;
	logic [2:0] param_cnt;
	logic [7:0] high_byte;
	logic [ROW_W-1:0] partial_start_row;
	logic [ROW_W-1:0] partial_end_row;
	logic [ROW_W-1:0] top_fixed_lines;
	logic [ROW_W-1:0] scroll_height_lines;
	logic [ROW_W-1:0] bottom_fixed_lines;
	logic scroll_mode;
	logic tear_enable;
	logic cmd_strobe;
	logic data_strobe;
	logic [ROW_W-1:0] word;
	logic [ROW_W-1:0] last_row;
	logic in_top;
	logic in_bottom;

	// gate mode decode; reserved code 11 treated as 240 lines
	function automatic logic [15:0] pst_last_row(input logic [1:0] gm);
		logic [15:0] r;
		r = PST_LAST_ROW_240;
		if (gm == PST_GM_208) begin
			r = PST_LAST_ROW_208;
		end else if (gm == PST_GM_220) begin
			r = PST_LAST_ROW_220;
		end
		return r;
	endfunction : pst_last_row

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_n <= rst_sync1;
		end
	end

	// no mode gating: every write is decoded in every power mode
	assign cmd_strobe = wr_strobe_in && !cmd_data_select_in;
	assign data_strobe = wr_strobe_in && cmd_data_select_in;
	assign word = ROW_W'({high_byte, wr_data_in});
	assign last_row = ROW_W'(pst_last_row(gate_count_select_in));

	// parameter sequencer; any command byte aborts a pending sequence
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= PST_IDLE;
			param_cnt <= 3'h0;
		end else if (cmd_strobe) begin
			param_cnt <= 3'h0;
			unique case (wr_data_in)
				PST_CMD_PARTIAL_AREA: state <= PST_PARTIAL;
				PST_CMD_SCROLL_AREA: state <= PST_SCROLL;
				default: state <= PST_IDLE;
			endcase
		end else if (data_strobe && state != PST_IDLE) begin
			if ((state == PST_PARTIAL && param_cnt == PST_PARTIAL_PARAMS - 3'h1)
				|| (state == PST_SCROLL
				&& param_cnt == PST_SCROLL_PARAMS - 3'h1)) begin
				state <= PST_IDLE;
				param_cnt <= 3'h0;
			end else begin
				param_cnt <= param_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			high_byte <= 8'h00;
		end else if (data_strobe && !param_cnt[0]) begin
			high_byte <= wr_data_in;
		end
	end

	// partial window; hardware reset sets end to the 208 last row, software reset to the gate mode's last row
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			partial_start_row <= ROW_W'(PST_PARTIAL_START_RST);
			partial_end_row <= ROW_W'(PST_LAST_ROW_208);
		end else if (cmd_strobe && wr_data_in == PST_CMD_SW_RESET) begin
			partial_start_row <= ROW_W'(PST_PARTIAL_START_RST);
			partial_end_row <= last_row;
		end else if (data_strobe && state == PST_PARTIAL && param_cnt[0]) begin
			if (param_cnt[1]) begin
				partial_end_row <= word;
			end else begin
				partial_start_row <= word;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			top_fixed_lines <= ROW_W'(PST_SCROLL_RST);
			scroll_height_lines <= ROW_W'(PST_SCROLL_RST);
			bottom_fixed_lines <= ROW_W'(PST_SCROLL_RST);
		end else if (cmd_strobe && wr_data_in == PST_CMD_SW_RESET) begin
			top_fixed_lines <= ROW_W'(PST_SCROLL_RST);
			scroll_height_lines <= ROW_W'(PST_SCROLL_RST);
			bottom_fixed_lines <= ROW_W'(PST_SCROLL_RST);
		end else if (data_strobe && state == PST_SCROLL && param_cnt[0]) begin
			unique case (param_cnt)
				3'h1: top_fixed_lines <= word;
				3'h3: scroll_height_lines <= word;
				default: bottom_fixed_lines <= word;
			endcase
		end
	end

	// scroll mode starts at the start-address command
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			scroll_mode <= 1'b0;
		end else if (cmd_strobe) begin
			if (wr_data_in == PST_CMD_PARTIAL_ON
				|| wr_data_in == PST_CMD_NORMAL_ON
				|| wr_data_in == PST_CMD_SW_RESET) begin
				scroll_mode <= 1'b0;
			end else if (wr_data_in == PST_CMD_SCROLL_START) begin
				scroll_mode <= 1'b1;
			end
		end
	end

	// tear enable; clearing an already-clear flag is harmless
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			tear_enable <= 1'b0;
		end else if (cmd_strobe) begin
			if (wr_data_in == PST_CMD_TEAR_OFF
				|| wr_data_in == PST_CMD_SW_RESET) begin
				tear_enable <= 1'b0;
			end else if (wr_data_in == PST_CMD_TEAR_ON) begin
				tear_enable <= 1'b1;
			end
		end
	end

	// fixed-area membership, counted from opposite ends per scan order
	always_comb begin
		in_top = 1'b0;
		in_bottom = 1'b0;
		if (!scan_order_bit_in) begin
			in_top = scan_row_in < top_fixed_lines;
			in_bottom = (last_row - scan_row_in) < bottom_fixed_lines;
		end else begin
			in_top = (last_row - scan_row_in) < top_fixed_lines;
			in_bottom = scan_row_in < bottom_fixed_lines;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			row_in_partial_out <= 1'b0;
			row_in_top_fixed_out <= 1'b0;
			row_in_bottom_fixed_out <= 1'b0;
		end else begin
			if (partial_end_row >= partial_start_row) begin
				row_in_partial_out <= scan_row_in >= partial_start_row
					&& scan_row_in <= partial_end_row;
			end else begin
				row_in_partial_out <= scan_row_in >= partial_start_row
					|| scan_row_in <= partial_end_row;
			end
			row_in_top_fixed_out <= in_top;
			row_in_bottom_fixed_out <= in_bottom;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			partial_start_row_out <= '0;
			partial_end_row_out <= '0;
			top_fixed_lines_out <= '0;
			scroll_height_lines_out <= '0;
			bottom_fixed_lines_out <= '0;
			scroll_mode_out <= 1'b0;
			scan_order_bit_out <= 1'b0;
			tear_signal_enable_out <= 1'b0;
			tear_signal_out <= 1'b0;
		end else begin
			partial_start_row_out <= partial_start_row;
			partial_end_row_out <= partial_end_row;
			top_fixed_lines_out <= top_fixed_lines;
			scroll_height_lines_out <= scroll_height_lines;
			bottom_fixed_lines_out <= bottom_fixed_lines;
			scroll_mode_out <= scroll_mode;
			scan_order_bit_out <= scan_order_bit_in;
			tear_signal_enable_out <= tear_enable;
			// blanking pulse generation lives in the scan logic
			tear_signal_out <= 1'b0;
		end
	end
endmodule : pst_cmd

// >>> bench/pst_cmd_assertions.sv
// port checker for the partial, scroll and tear-line command handler
module pst_cmd_assertions
	import pst_pkg::*;
#(
	parameter int ROW_W = 16
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic wr_strobe_in,
	input wire logic cmd_data_select_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [1:0] gate_count_select_in,
	input wire logic scan_order_bit_in,
	input wire logic [ROW_W-1:0] scan_row_in,
	input wire logic [ROW_W-1:0] partial_start_row_out,
	input wire logic [ROW_W-1:0] partial_end_row_out,
	input wire logic [ROW_W-1:0] top_fixed_lines_out,
	input wire logic [ROW_W-1:0] bottom_fixed_lines_out,
	input wire logic scroll_mode_out,
	input wire logic scan_order_bit_out,
	input wire logic row_in_partial_out,
	input wire logic row_in_top_fixed_out,
	input wire logic row_in_bottom_fixed_out,
	input wire logic tear_signal_enable_out,
	input wire logic tear_signal_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] rcnt;
	wire logic cmd = wr_strobe_in && !cmd_data_select_in;
	wire logic ton = cmd && wr_data_in == PST_CMD_TEAR_ON;
	wire logic toff = cmd && wr_data_in == PST_CMD_TEAR_OFF;
	wire logic mexit = cmd && (wr_data_in == PST_CMD_PARTIAL_ON ||
		wr_data_in == PST_CMD_NORMAL_ON);
	wire logic [ROW_W-1:0] last = ROW_W'(gate_count_select_in == PST_GM_208 ?
		PST_LAST_ROW_208 : gate_count_select_in == PST_GM_220 ?
		PST_LAST_ROW_220 : PST_LAST_ROW_240);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	// $past is meaningless until the synchroniser has let go
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rcnt <= 2'h0;
		end else if (rcnt != 2'h3) begin
			rcnt <= rcnt + 2'h1;
		end
	end
	function automatic logic in_win(input logic [ROW_W-1:0] r, s, e);
		return s <= e ? r >= s && r <= e : r >= s || r <= e;
	endfunction : in_win
	property p_tear_low; tear_signal_out == 1'b0; endproperty
	a_tear_low: assert property (p_tear_low) else $error("tear high");
	property p_tear_off;
		toff ##1 !cmd |-> ##1 !tear_signal_enable_out;
	endproperty
	a_tear_off: assert property (p_tear_off) else $error("tear on");
	property p_tear_set;
		$rose(tear_signal_enable_out) |-> $past(ton, 2);
	endproperty
	a_tear_set: assert property (p_tear_set) else $error("tear set");
	property p_exit; mexit ##1 !cmd |-> ##1 !scroll_mode_out; endproperty
	a_exit: assert property (p_exit) else $error("scroll kept");
	property p_order; rcnt == 2'h3 |->
		scan_order_bit_out == $past(scan_order_bit_in); endproperty
	a_order: assert property (p_order) else $error("scan order");
	property p_window; rcnt == 2'h3 && $stable(partial_start_row_out) &&
		$stable(partial_end_row_out) |-> row_in_partial_out == in_win(
		$past(scan_row_in), partial_start_row_out, partial_end_row_out);
	endproperty
	a_window: assert property (p_window) else $error("window");
	property p_top; rcnt == 2'h3 && $stable(top_fixed_lines_out) &&
		$stable(scan_order_bit_out) |-> row_in_top_fixed_out ==
		(scan_order_bit_out ?
		$past(last) - $past(scan_row_in) < top_fixed_lines_out :
		$past(scan_row_in) < top_fixed_lines_out); endproperty
	a_top: assert property (p_top) else $error("top fixed");
	property p_bot; rcnt == 2'h3 && $stable(bottom_fixed_lines_out) &&
		$stable(scan_order_bit_out) |-> row_in_bottom_fixed_out ==
		(scan_order_bit_out ? $past(scan_row_in) < bottom_fixed_lines_out :
		$past(last) - $past(scan_row_in) < bottom_fixed_lines_out);
	endproperty
	a_bot: assert property (p_bot) else $error("bottom fixed");
endmodule : pst_cmd_assertions

// >>> bench/pst_host.sv
// host processor model writing command and parameter bytes
module pst_host (
	input wire logic clk_in,
	output logic strobe_out,
	output logic sel_out,
	output logic [7:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		strobe_out = 1'b0;
		sel_out = 1'b0;
		data_out = 8'h00;
	end
	// data inverted once the strobe is gone, so stale bytes never match
	task automatic put(input logic sel, input logic [7:0] d);
		@(posedge clk_in);
		strobe_out <= 1'b1;
		sel_out <= sel;
		data_out <= d;
		@(posedge clk_in);
		strobe_out <= 1'b0;
		data_out <= ~d;
	endtask : put
	task automatic word(input logic [15:0] w);
		put(1'b1, w[15:8]);
		put(1'b1, w[7:0]);
	endtask : word
endmodule : pst_host

// >>> bench/pst_cmd_bench.sv
// self-checking bench for the command handler
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module pst_cmd_bench
	import pst_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic so = 1'b0;
	logic [15:0] row = 16'h0000;
	logic [1:0] gm = PST_GM_208;
	logic stb, sel, sm, sob, rip, rit, rib, ten, tso;
	logic [7:0] dat;
	logic [15:0] ps, pe, tf, sh, bf;
	int bad_count = 0;
	int n_compared = 0;
	initial forever #2 clk = ~clk;
	pst_host i_host (.clk_in(clk), .strobe_out(stb), .sel_out(sel),
		.data_out(dat));
	pst_cmd i_dut (.mclk_in(clk), .rstn_in(rstn), .wr_strobe_in(stb),
		.cmd_data_select_in(sel), .wr_data_in(dat),
		.gate_count_select_in(gm), .scan_order_bit_in(so),
		.scan_row_in(row), .partial_start_row_out(ps),
		.partial_end_row_out(pe), .top_fixed_lines_out(tf),
		.scroll_height_lines_out(sh), .bottom_fixed_lines_out(bf),
		.scroll_mode_out(sm), .scan_order_bit_out(sob),
		.row_in_partial_out(rip), .row_in_top_fixed_out(rit),
		.row_in_bottom_fixed_out(rib), .tear_signal_enable_out(ten),
		.tear_signal_out(tso));
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic t_partial;
		logic [15:0] s[2] = '{16'h00c0, 16'h0020};
		logic [15:0] e[2] = '{16'h0010, 16'h0020};
		for (int i = 0; i < 2; i++) begin
			i_host.put(1'b0, PST_CMD_PARTIAL_AREA);
			i_host.word(s[i]);
			i_host.word(e[i]);
			@(posedge clk);
			row <= s[i];
			settle();
			`CHK("window", {s[i], e[i], 1'b1}, {ps, pe, rip})
		end
		$display("partial done");
	endtask : t_partial
	task automatic t_scroll;
		logic [7:0] ex[2] = '{PST_CMD_PARTIAL_ON, PST_CMD_NORMAL_ON};
		i_host.put(1'b0, PST_CMD_SCROLL_AREA);
		i_host.word(16'h000a);
		i_host.word(16'h00c0);
		i_host.word(16'h0006);
		@(posedge clk);
		so <= 1'b1;
		row <= 16'h00cf;
		settle();
		`CHK("scroll", 48'h000a00c00006, {tf, sh, bf})
		`CHK("order 1", 3'b101, {rit, rib, sob})
		@(posedge clk);
		so <= 1'b0;
		row <= 16'h00cc;
		settle();
		`CHK("fixed", 3'b010, {rit, rib, sob})
		for (int i = 0; i < 2; i++) begin
			// access control is never rewritten while scrolling
			i_host.put(1'b0, PST_CMD_SCROLL_START);
			i_host.word(16'h000a);
			settle();
			`CHK("mode on", 1'b1, sm)
			i_host.put(1'b0, ex[i]);
			settle();
			`CHK("mode off", 1'b0, sm)
		end
		$display("scroll done");
	endtask : t_scroll
	task automatic t_tear;
		i_host.put(1'b0, PST_CMD_TEAR_ON);
		i_host.put(1'b1, 8'h00);
		settle();
		`CHK("tear on", 1'b1, ten)
		repeat (2) begin
			i_host.put(1'b0, PST_CMD_TEAR_OFF);
			settle();
			`CHK("tear off", 2'b00, {ten, tso})
		end
		$display("tear done");
	endtask : t_tear
	// software reset under a larger gate mode: end row follows the mode
	task automatic t_swreset;
		@(posedge clk);
		gm <= 2'h2;
		i_host.put(1'b0, PST_CMD_TEAR_ON);
		i_host.put(1'b1, 8'h00);
		i_host.put(1'b0, PST_CMD_SCROLL_START);
		settle();
		`CHK("before", 2'b11, {ten, sm})
		i_host.put(1'b0, PST_CMD_SW_RESET);
		settle();
		`CHK("swrst", {32'hef, 50'h0}, {ps, pe, tf, sh, bf, ten, sm})
		$display("sw reset done");
	endtask : t_swreset
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK("rst", {32'hcf, 51'h0}, {ps, pe, tf, sh, bf, ten, sm, tso})
		t_partial();
		t_scroll();
		t_tear();
		t_swreset();
		summarize();
	end
	initial begin
		#4000;
		bad_count++;
		summarize();
	end
endmodule : pst_cmd_bench
bind pst_cmd pst_cmd_assertions #(.ROW_W(ROW_W)) i_chk (.mclk_in, .rstn_in,
	.wr_strobe_in, .cmd_data_select_in, .wr_data_in, .gate_count_select_in,
	.scan_order_bit_in, .scan_row_in, .partial_start_row_out,
	.partial_end_row_out, .top_fixed_lines_out, .bottom_fixed_lines_out,
	.scroll_mode_out, .scan_order_bit_out, .row_in_partial_out,
	.row_in_top_fixed_out, .row_in_bottom_fixed_out, .tear_signal_enable_out,
	.tear_signal_out);
